// ===== rtl/lim_intr_ctrl.sv
`timescale 1ns/1ps
module lim_intr_ctrl (
   input  wire logic                       CORE_CLK_I,
   input  wire logic                       RESET_N_I,
   input  wire logic [lim_pkg::REG_AW-1:0] PADDR_I,
   input  wire logic                       PSEL_I,
   input  wire logic                       PENABLE_I,
   input  wire logic                       PWRITE_I,
   input  wire logic [31:0]                PWDATA_I,
   input  wire logic [7:0]                 LINE_STATUS_I,
   input  wire logic [7:0]                 SRC_EVENT_I,
   output logic      [31:0]                PRDATA_O,
   output logic                            PREADY_O,
   output logic                            PSLVERR_O,
   output logic                            IRQ_O
);

   ////////////////////////////////////////////////////////////////////////
   logic                  rst_meta;
   logic                  rst_n;
   lim_pkg::lim_apb_req_s req;
   logic [7:0]            mask_first;
   logic [7:0]            mask_second;
   logic [7:0]            edge_sel;
   logic [7:0]            status_prev;
   logic [7:0]            line_event;
   logic [7:0]            line_latched;
   logic [7:0]            src_latched;
   logic [9:0]            word_idx;
   logic                  access;
   logic                  wr;
   logic                  rd_evt;
   logic                  rd_src;
   logic                  mapped;
   logic [7:0]            next_rdata;

   assign req = '{paddr: PADDR_I, psel: PSEL_I, penable: PENABLE_I,
                  pwrite: PWRITE_I, pwdata: PWDATA_I};

   // Release of reset is synchronised; assertion stays asynchronous
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB decode: setup cycle, then a one-cycle access with pready high
   assign word_idx = req.paddr[lim_pkg::REG_AW-1:2];
   assign access   = req.psel && req.penable && PREADY_O;
   assign wr       = access && req.pwrite;
   assign rd_evt   = access && !req.pwrite &&
                     word_idx == {2'b00, lim_pkg::IDX_EVENT_STATUS};
   assign rd_src   = access && !req.pwrite &&
                     word_idx == {2'b00, lim_pkg::IDX_SRC_EVENT};

   always_comb begin
      mapped     = 1'b1;
      next_rdata = 8'h00;
      if (req.paddr[1:0] != 2'b00 || word_idx[9:8] != 2'b00) begin
         mapped = 1'b0;
      end else begin
         unique case (word_idx[7:0])
            lim_pkg::IDX_MASK_FIRST:   next_rdata = mask_first;
            lim_pkg::IDX_MASK_SECOND:  next_rdata = mask_second;
            lim_pkg::IDX_EDGE_SEL:     next_rdata = edge_sel;
            lim_pkg::IDX_STATUS_RT:    next_rdata = LINE_STATUS_I;
            lim_pkg::IDX_EVENT_STATUS: next_rdata = line_latched;
            lim_pkg::IDX_SRC_EVENT:    next_rdata = src_latched;
            default:                   mapped = 1'b0;
         endcase
      end
   end

   // Ready rises in the access cycle, so every transfer takes two cycles
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= 32'h0000_0000;
      end else begin
         PREADY_O  <= req.psel && !req.penable;
         PSLVERR_O <= req.psel && !req.penable && !mapped;
         if (req.psel && !req.penable && !req.pwrite) begin
            PRDATA_O <= {24'h00_0000, next_rdata};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mask and edge select registers; only the low byte is stored
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         mask_first  <= lim_pkg::MASK_RESET;
         mask_second <= lim_pkg::MASK_RESET;
         edge_sel    <= lim_pkg::EDGE_SEL_RESET;
      end else if (wr && req.paddr[1:0] == 2'b00 &&
                   word_idx[9:8] == 2'b00) begin
         if (word_idx[7:0] == lim_pkg::IDX_MASK_FIRST) begin
            mask_first <= req.pwdata[7:0];
         end
         if (word_idx[7:0] == lim_pkg::IDX_MASK_SECOND) begin
            mask_second <= req.pwdata[7:0];
         end
         if (word_idx[7:0] == lim_pkg::IDX_EDGE_SEL) begin
            edge_sel <= req.pwdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Edge qualification, one slice per status bit
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         status_prev <= 8'h00;
      end else begin
         status_prev <= LINE_STATUS_I;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_edge
         // Rise always counts; fall counts only with both-edge select
         assign line_event[g] = (LINE_STATUS_I[g] && !status_prev[g]) ||
            (edge_sel[g] && !LINE_STATUS_I[g] && status_prev[g]);
      end
   endgenerate

   // Sticky flags, cleared by reading them; a new event beats the clear
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         line_latched <= 8'h00;
      end else begin
         line_latched <= (rd_evt ? 8'h00 : line_latched) | line_event;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         src_latched <= 8'h00;
      end else begin
         src_latched <= (rd_src ? 8'h00 : src_latched) | SRC_EVENT_I;
      end
   end

   // Masked flags still latch but never reach the output
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= |(line_latched & ~mask_first) |
                  |(src_latched & ~mask_second);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   AST_MASK_RESET: assert property (@(posedge CORE_CLK_I)
      $rose(rst_n) |-> mask_second == 8'hFF && mask_first == 8'hFF)
      else $error("mask registers not all ones after reset");

   AST_RISE_LATCH: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      $rose(LINE_STATUS_I[0]) |=> line_latched[0])
      else $error("rising status edge not latched");

   AST_FALL_RISE_ONLY: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      $fell(LINE_STATUS_I[7]) && !edge_sel[7] && !line_latched[7] &&
      !rd_evt |=> !line_latched[7])
      else $error("fall latched with rise-only select");

   AST_FALL_BOTH: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      $fell(LINE_STATUS_I[6]) && edge_sel[6] |=> line_latched[6])
      else $error("fall not latched with both-edge select");

   AST_SRC_LATCH: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      SRC_EVENT_I[2] |=> src_latched[2])
      else $error("source event not latched");

   AST_IRQ_ENABLED: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      src_latched[0] && !mask_second[0] |=> IRQ_O)
      else $error("enabled event did not raise interrupt");

   AST_IRQ_MASKED: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      (line_latched & ~mask_first) == 8'h00 &&
      (src_latched & ~mask_second) == 8'h00 |=> !IRQ_O)
      else $error("interrupt high with all flags masked");

   AST_READ_CLEAR: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      rd_evt && line_event == 8'h00 |=> line_latched == 8'h00)
      else $error("read did not clear status");

   AST_WRITE_EDGE: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      wr && req.paddr[1:0] == 2'b00 &&
      word_idx == {2'b00, lim_pkg::IDX_EDGE_SEL} |=>
      edge_sel == $past(req.pwdata[7:0]))
      else $error("edge select write lost");

   AST_READY_TWO: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      req.psel && !req.penable |=> PREADY_O)
      else $error("pready late");

   // Edge selects must come out of reset as rise-only
   AST_EDGE_SEL_RESET: assert property (@(posedge CORE_CLK_I)
      $rose(rst_n) |-> edge_sel == lim_pkg::EDGE_SEL_RESET)
      else $error("edge select not cleared by reset");

   // Same checks on every status slice, not just the sampled ones above
   for (g = 0; g < 8; g++) begin : g_edge_chk
      AST_RISE_ANY: assert property (@(posedge CORE_CLK_I)
         disable iff (!rst_n)
         $rose(LINE_STATUS_I[g]) |=> line_latched[g])
         else $error("rising status edge not latched");
      AST_FALL_SEL: assert property (@(posedge CORE_CLK_I)
         disable iff (!rst_n)
         $fell(LINE_STATUS_I[g]) && edge_sel[g] |=> line_latched[g])
         else $error("fall not latched with both-edge select");
      AST_FALL_IGNORE: assert property (@(posedge CORE_CLK_I)
         disable iff (!rst_n)
         $fell(LINE_STATUS_I[g]) && !edge_sel[g] && !line_latched[g] &&
         !rd_evt |=> !line_latched[g])
         else $error("fall latched with rise-only select");
      AST_LINE_HOLD: assert property (@(posedge CORE_CLK_I)
         disable iff (!rst_n)
         line_latched[g] && !rd_evt |=> line_latched[g])
         else $error("status flag lost without a read");
      AST_FIRST_IRQ: assert property (@(posedge CORE_CLK_I)
         disable iff (!rst_n)
         line_latched[g] && !mask_first[g] |=> IRQ_O)
         else $error("unmasked status flag did not raise interrupt");
   end

   // Masked sources still latch, so unmasking later is not lossy
   for (g = 0; g < 8; g++) begin : g_src_chk
      AST_SRC_ANY: assert property (@(posedge CORE_CLK_I)
         disable iff (!rst_n)
         SRC_EVENT_I[g] |=> src_latched[g])
         else $error("source event not latched");
      AST_SRC_HOLD: assert property (@(posedge CORE_CLK_I)
         disable iff (!rst_n)
         src_latched[g] && !rd_src |=> src_latched[g])
         else $error("source flag lost without a read");
   end

   // One check per named second-mask bit 7 to 1; bit 0 is checked by AST_IRQ_ENABLED
   AST_DAC_IRQ: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      src_latched[lim_pkg::BIT_DAC_OVERFLOW] &&
      !mask_second[lim_pkg::BIT_DAC_OVERFLOW] |=> IRQ_O)
      else $error("enabled overflow event did not raise interrupt");

   AST_JA_OVF_IRQ: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      src_latched[lim_pkg::BIT_JA_OVERFLOW] &&
      !mask_second[lim_pkg::BIT_JA_OVERFLOW] |=> IRQ_O)
      else $error("enabled attenuator overflow did not raise interrupt");

   AST_JA_UNDF_IRQ: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      src_latched[lim_pkg::BIT_JA_UNDERFLOW] &&
      !mask_second[lim_pkg::BIT_JA_UNDERFLOW] |=> IRQ_O)
      else $error("enabled attenuator underflow did not raise interrupt");

   AST_PAT_ERR_IRQ: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      src_latched[lim_pkg::BIT_PATTERN_ERROR] &&
      !mask_second[lim_pkg::BIT_PATTERN_ERROR] |=> IRQ_O)
      else $error("enabled pattern error did not raise interrupt");

   AST_EXZ_IRQ: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      src_latched[lim_pkg::BIT_EXCESS_ZEROS] &&
      !mask_second[lim_pkg::BIT_EXCESS_ZEROS] |=> IRQ_O)
      else $error("enabled excess zeros did not raise interrupt");

   AST_CV_IRQ: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      src_latched[lim_pkg::BIT_CODE_VIOLATION] &&
      !mask_second[lim_pkg::BIT_CODE_VIOLATION] |=> IRQ_O)
      else $error("enabled code violation did not raise interrupt");

   AST_TICK_IRQ: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      src_latched[lim_pkg::BIT_SECOND_TICK] &&
      !mask_second[lim_pkg::BIT_SECOND_TICK] |=> IRQ_O)
      else $error("enabled timer event did not raise interrupt");

   AST_WRITE_MASK_FIRST: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      wr && req.paddr[1:0] == 2'b00 &&
      word_idx == {2'b00, lim_pkg::IDX_MASK_FIRST} |=>
      mask_first == $past(req.pwdata[7:0]))
      else $error("first mask write lost");

   AST_WRITE_MASK_SECOND: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      wr && req.paddr[1:0] == 2'b00 &&
      word_idx == {2'b00, lim_pkg::IDX_MASK_SECOND} |=>
      mask_second == $past(req.pwdata[7:0]))
      else $error("second mask write lost");

   // A new event in the clearing read must survive the clear
   AST_SET_WINS: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      rd_evt |=> line_latched == $past(line_event))
      else $error("status read lost a coincident event");

   AST_SRC_SET_WINS: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      rd_src |=> src_latched == $past(SRC_EVENT_I))
      else $error("source read lost a coincident event");

   AST_SRC_CLEAR: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      rd_src && SRC_EVENT_I == 8'h00 |=> src_latched == 8'h00)
      else $error("read did not clear source flags");

   AST_ERR_UNMAPPED: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      req.psel && !req.penable && !mapped |=> PSLVERR_O)
      else $error("unmapped access not flagged");

   AST_ERR_MAPPED: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      req.psel && !req.penable && mapped |=> !PSLVERR_O)
      else $error("mapped access flagged as error");

   AST_READY_ONE: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      PREADY_O |=> !PREADY_O)
      else $error("pready held beyond the access cycle");

   AST_RDATA_UPPER: assert property (@(posedge CORE_CLK_I)
      disable iff (!rst_n)
      PRDATA_O[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");

   COV_SRC_IRQ: cover property (@(posedge CORE_CLK_I)
      disable iff (!rst_n) rd_src && src_latched != 8'h00);
   COV_BOTH_EDGE: cover property (@(posedge CORE_CLK_I)
      disable iff (!rst_n) edge_sel[3] && $fell(LINE_STATUS_I[3]));
   COV_IRQ: cover property (@(posedge CORE_CLK_I)
      disable iff (!rst_n) $rose(IRQ_O));
   COV_SET_CLEAR: cover property (@(posedge CORE_CLK_I)
      disable iff (!rst_n) rd_evt && line_event != 8'h00);

endmodule

// ===== rtl/lim_pkg.sv
// Functional notes
// - Second mask bit 7 gates DAC overflow; 0 enables, 1 masks, resets 1.
// - Second mask bits 6 and 5 gate jitter overflow and underflow; reset 1.
// - Second mask bit 4 gates pattern logic error; 0 enables, resets masked.
// - Bits 3 and 2 gate excess zeros and code violation; reset masked.
// - Second mask bit 1 gates the one-second timer event; resets 1.
// - Second mask bit 0 gates counter overflow event; resets 1.
// - Edge bit 7: equalizer range event on rise (0) or both edges (1).
// - Edge bit 6: loop activate event on rise (0) or both edges (1).
// - Edge bit 5: loop deactivate event on rise (0) or both edges (1).
// - Edge bit 4: pattern sync event on rise (0) or both edges (1).
// - Edge bit 3: transmit clock loss event on rise or both edges.
// - Edge bit 2: driver failure event on rise or both edges.
// - Edge bit 1: alarm indication event on rise or both edges.
// - Edge bit 0: loss of signal event on rise or both edges.
// - First mask gates eight status events, same bit order, reset 1.
package lim_pkg;

   localparam int          REG_AW              = 12;
   // Printed offsets are not word multiples, so they are indices
   localparam logic [7:0]  IDX_MASK_FIRST      = 8'h14;
   localparam logic [7:0]  IDX_MASK_SECOND     = 8'h15;
   localparam logic [7:0]  IDX_EDGE_SEL        = 8'h16;
   localparam logic [7:0]  IDX_STATUS_RT       = 8'h17;
   localparam logic [7:0]  IDX_EVENT_STATUS    = 8'h18;
   localparam logic [7:0]  IDX_SRC_EVENT       = 8'h19;
   localparam logic [7:0]  MASK_RESET          = 8'hFF;
   localparam logic [7:0]  EDGE_SEL_RESET      = 8'h00;

   // Bit positions of the second mask register
   localparam int          BIT_DAC_OVERFLOW    = 7;
   localparam int          BIT_JA_OVERFLOW     = 6;
   localparam int          BIT_JA_UNDERFLOW    = 5;
   localparam int          BIT_PATTERN_ERROR   = 4;
   localparam int          BIT_EXCESS_ZEROS    = 3;
   localparam int          BIT_CODE_VIOLATION  = 2;
   localparam int          BIT_SECOND_TICK     = 1;
   localparam int          BIT_COUNTER_OVF     = 0;

   typedef struct packed {
      logic [REG_AW-1:0] paddr;
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [31:0]       pwdata;
   } lim_apb_req_s;

endpackage

// ===== testbench/lim_intr_ctrl_tb.sv
`timescale 1ns/1ps
module lim_intr_ctrl_tb;
   localparam logic [11:0] A_MF = 12'h050;
   localparam logic [11:0] A_MS = 12'h054;
   localparam logic [11:0] A_ES = 12'h058;
   localparam logic [11:0] A_EV = 12'h060;
   localparam logic [11:0] A_SE = 12'h064;
   localparam int          LIMIT = 20000;
   logic                       clk;
   logic                       rst_n;
   logic [lim_pkg::REG_AW-1:0] paddr;
   logic                       psel;
   logic                       penable;
   logic                       pwrite;
   logic [31:0]                pwdata;
   logic [7:0]                 line_status;
   logic [7:0]                 src_event;
   logic [31:0]                prdata;
   logic                       pready;
   logic                       pslverr;
   logic                       irq;
   logic [31:0]                rd;
   logic                       er;
   int                         err_total = 0;
   int                         n_compared = 0;
   int                         cycles = 0;

   lim_intr_ctrl lim_intr_ctrl_inst (
      .CORE_CLK_I (clk),   .RESET_N_I (rst_n),   .PADDR_I (paddr),
      .PSEL_I (psel),      .PENABLE_I (penable), .PWRITE_I (pwrite),
      .PWDATA_I (pwdata),  .LINE_STATUS_I (line_status),
      .SRC_EVENT_I (src_event), .PRDATA_O (prdata), .PREADY_O (pready),
      .PSLVERR_O (pslverr), .IRQ_O (irq));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: saw %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Entered just after an edge; request held until PREADY is sampled
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic pulse(input logic [7:0] v);
      src_event <= v;
      @(posedge clk);
      src_event <= 8'h00;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      apb(0, A_MF, 0); chk(rd, 32'h000000FF);
      apb(0, A_MS, 0); chk(rd, 32'h000000FF);
      apb(0, A_ES, 0); chk(rd, 32'h00000000);
      apb(1, 12'h055, 0); chk({31'h0, er}, 32'h1);
      apb(0, 12'h070, 0); chk({31'h0, er}, 32'h1);
      apb(0, A_MS, 0); chk(rd, 32'h000000FF);
      apb(1, A_MS, 32'h5A5A5AA5); chk({31'h0, er}, 32'h0);
      apb(0, A_MS, 0); chk(rd, 32'h000000A5);
      line_status <= 8'h81;
      idle(2);
      apb(0, 12'h05C, 0); chk(rd, 32'h00000081);
      chk({31'h0, er}, 32'h0);
      line_status <= 8'h00;
      idle(2);
      apb(0, A_EV, 0); chk(rd, 32'h00000081);
      apb(1, A_MS, 32'hFF);
   endtask

   // Each status bit: rise only, then both edges
   task automatic t_edges();
      for (int i = 0; i < 8; i++) begin
         for (int s = 0; s < 2; s++) begin
            apb(1, A_ES, s ? (32'h1 << i) : 32'h0);
            line_status <= 8'h01 << i;
            idle(4);
            apb(0, A_EV, 0); chk(rd, 32'h1 << i);
            line_status <= 8'h00;
            idle(4);
            apb(0, A_EV, 0); chk(rd, s ? (32'h1 << i) : 0);
         end
      end
      apb(1, A_ES, 0);
   endtask

   task automatic t_first_irq();
      apb(1, A_MF, 32'hFE);
      line_status <= 8'h02;
      idle(4); chk({31'h0, irq}, 32'h0);
      line_status <= 8'h03;
      idle(4); chk({31'h0, irq}, 32'h1);
      apb(0, A_EV, 0); chk(rd, 32'h3);
      idle(3); chk({31'h0, irq}, 32'h0);
      apb(1, A_MF, 32'hFF);
      line_status <= 8'h07;
      idle(4); chk({31'h0, irq}, 32'h0);
      // A flag latched while masked must raise the line once unmasked
      apb(1, A_MF, 32'hFB);
      idle(3); chk({31'h0, irq}, 32'h1);
      apb(0, A_EV, 0); chk(rd, 32'h4);
      line_status <= 8'h00;
      apb(1, A_MF, 32'hFF);
   endtask

   task automatic t_second_irq();
      for (int i = 0; i < 8; i++) begin
         apb(1, A_MS, ~(32'h1 << i) & 32'hFF);
         pulse(8'h01 << ((i + 1) % 8));
         idle(3); chk({31'h0, irq}, 32'h0);
         pulse(8'h01 << i);
         idle(3); chk({31'h0, irq}, 32'h1);
         apb(0, A_SE, 0); chk(rd, (32'h1 << i) | (32'h1 << ((i + 1) % 8)));
         idle(3); chk({31'h0, irq}, 32'h0);
      end
      apb(1, A_MS, 32'hFF);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_total++;
         complete_run();
      end
   end

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      line_status = 8'h00;
      src_event = 8'h00;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      idle(3);
      t_regs();
      t_edges();
      t_first_irq();
      t_second_irq();
      complete_run();
   end
endmodule
